// >>> rtl/dmacra_consts.svh
// Offsets, field positions and reset values for the DMA channel block
`ifndef DMACRA_CONSTS_SVH
`define DMACRA_CONSTS_SVH
`define DMACRA_ADDR_HI_BIT     3
`define DMACRA_ADDR_CH_MSB     2
`define DMACRA_ADDR_CH_LSB     1
`define DMACRA_ADDR_SEL_BIT    0
`define DMACRA_SEL_ADDRESS     1'b0
`define DMACRA_SEL_WORD_COUNT  1'b1
`define DMACRA_CMD_CLR_BYTE_FF 4'hC
`define DMACRA_CMD_SET_BYTE_FF 4'hC
`define DMACRA_CMD_MASTER_CLR  4'hD
`define DMACRA_REG_RESET       16'h0000
`define DMACRA_BYTE_FF_RESET   1'b0
`endif

// >>> rtl/dmacra_pkg.sv
// Types shared by the DMA channel block
`default_nettype none
package dmacra_pkg;
  typedef enum logic [1:0] {DMACRA_IDLE, DMACRA_S1, DMACRA_S2, DMACRA_S4} dmacra_state_e;
  typedef logic [15:0] dmacra_word_t;
  typedef logic [1:0]  dmacra_chan_t;
endpackage : dmacra_pkg
`default_nettype wire

// >>> rtl/dmacra_regbus_if.sv
// Register write carrier between the port decoder and the register file
`timescale 1ns/1ps
`default_nettype none
interface dmacra_regbus_if;
  import dmacra_pkg::*;
  logic         wr_en;
  logic         sel_wc;
  logic         hi_byte;
  dmacra_chan_t chan;
  logic [7:0]   wdata;
  logic         adv_en;
  dmacra_chan_t adv_chan;
  modport ctrl (output wr_en, sel_wc, hi_byte, chan, wdata, adv_en, adv_chan);
  modport regs (input  wr_en, sel_wc, hi_byte, chan, wdata, adv_en, adv_chan);
endinterface : dmacra_regbus_if
`default_nettype wire

// >>> rtl/dmacra_regfile.sv
// Base and current address and word count storage for four channels
`timescale 1ns/1ps
`default_nettype none
`include "dmacra_consts.svh"
module dmacra_regfile
  import dmacra_pkg::*;
(
  // Clock and reset
  input  wire logic     clk_sys,
  input  wire logic     rst,
  // Write and advance port
  dmacra_regbus_if.regs bus,
  // Current copies
  output dmacra_word_t  cur_addr [4],
  output dmacra_word_t  cur_wc   [4]
);
  dmacra_word_t base_addr_q [4];
  dmacra_word_t base_wc_q   [4];
  dmacra_word_t cur_addr_q  [4];
  dmacra_word_t cur_wc_q    [4];

  function automatic dmacra_word_t merge_byte(input dmacra_word_t old, input logic hi, input logic [7:0] b);
    merge_byte = hi ? {b, old[7:0]} : {old[15:8], b};
  endfunction : merge_byte

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 4; i++) begin
      if (rst) begin
        base_addr_q[i] <= `DMACRA_REG_RESET;
        base_wc_q[i]   <= `DMACRA_REG_RESET;
        cur_addr_q[i]  <= `DMACRA_REG_RESET;
        cur_wc_q[i]    <= `DMACRA_REG_RESET;
      end else if (bus.wr_en && bus.chan == 2'(i)) begin
        if (bus.sel_wc) begin
          base_wc_q[i] <= merge_byte(base_wc_q[i], bus.hi_byte, bus.wdata);
          cur_wc_q[i]  <= merge_byte(cur_wc_q[i], bus.hi_byte, bus.wdata);
        end else begin
          base_addr_q[i] <= merge_byte(base_addr_q[i], bus.hi_byte, bus.wdata);
          cur_addr_q[i]  <= merge_byte(cur_addr_q[i], bus.hi_byte, bus.wdata);
        end
      end else if (bus.adv_en && bus.adv_chan == 2'(i)) begin
        cur_addr_q[i] <= cur_addr_q[i] + 16'h0001;
        cur_wc_q[i]   <= cur_wc_q[i] - 16'h0001;
      end
    end
  end

  assign cur_addr = cur_addr_q;
  assign cur_wc   = cur_wc_q;
endmodule : dmacra_regfile
`default_nettype wire

// >>> rtl/dmacra_top.sv
// DMA channel register access, external end of process and fly-by transfer sequencing
// Notes on behaviour
// - End of process pin is open drain, both ways
// - External end of process ignored while idle
// - Latched end of process acts at second state
// - Return to idle discards latched end
// - Demand gaps are idle; pulses there ignored
// - Port decode picks channel and register kind
// - Byte flip-flop orders low then high byte
// - Unmasked request raises bus hold request
// - No address or strobes before hold grant
// - I/O read with memory write, or reverse
// - Transferred data never captured or driven
// - Upper address byte driven on data pins
// - Current write also loads base copy
`timescale 1ns/1ps
`default_nettype none
`include "dmacra_consts.svh"
module dmacra_top
  import dmacra_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Processor port
  input  wire logic       chip_select_n,
  input  wire logic [3:0] port_addr_in,
  input  wire logic [7:0] data_bus_pins_in,
  output logic [7:0]      data_bus_pins_out,
  output logic            data_bus_pins_oe,
  input  wire logic       io_read_strobe_n_in,
  input  wire logic       io_write_strobe_n_in,
  // Transfer setup
  input  wire logic [3:0] transfer_request_in,
  input  wire logic [3:0] request_mask,
  input  wire logic       demand_mode,
  input  wire logic       dir_mem_to_io,
  // Hold handshake
  output logic            bus_hold_request,
  input  wire logic       bus_hold_grant,
  // System bus outputs
  output logic            address_enable_out,
  output logic [7:0]      addr_low_out,
  output logic            io_read_strobe_n_out,
  output logic            io_write_strobe_n_out,
  output logic            memory_read_strobe_n,
  output logic            memory_write_strobe_n,
  output logic            strobe_oe,
  // End of process, open drain
  input  wire logic       end_of_process_n_in,
  output logic            end_of_process_n_out,
  output logic            end_of_process_oe,
  // Status
  output logic [3:0]      terminal_count_flags
);
  dmacra_regbus_if rb ();

  dmacra_state_e state_q, state_d;
  logic          byte_ff_q;
  logic [7:0]    rd_data_q;
  logic          rd_oe_q;
  logic          ext_eop_q;
  dmacra_chan_t  act_chan_q;
  logic [3:0]    tc_q;
  logic          eop_drive_q;
  logic          rd_prev_q;
  logic          wr_prev_q;
  dmacra_word_t  cur_addr [4];
  dmacra_word_t  cur_wc   [4];

  // Port decode
  wire          selected   = !chip_select_n && !port_addr_in[`DMACRA_ADDR_HI_BIT] && state_q == DMACRA_IDLE;
  wire          cmd_sel    = !chip_select_n && port_addr_in[`DMACRA_ADDR_HI_BIT] && state_q == DMACRA_IDLE;
  wire          rd_act     = !io_read_strobe_n_in;
  wire          wr_act     = !io_write_strobe_n_in;
  wire          rd_end     = rd_prev_q && !rd_act;
  wire          wr_end     = wr_prev_q && !wr_act;
  wire          wr_start   = wr_act && !wr_prev_q;
  wire          acc_end    = selected && (rd_end || wr_end);
  wire          clr_ff     = cmd_sel && wr_start && port_addr_in == `DMACRA_CMD_CLR_BYTE_FF;
  wire          set_ff     = cmd_sel && rd_act && !rd_prev_q && port_addr_in == `DMACRA_CMD_SET_BYTE_FF;
  wire          master_clr = cmd_sel && wr_start && port_addr_in == `DMACRA_CMD_MASTER_CLR;
  wire          sel_wc     = port_addr_in[`DMACRA_ADDR_SEL_BIT];
  wire dmacra_chan_t reg_chan = port_addr_in[`DMACRA_ADDR_CH_MSB:`DMACRA_ADDR_CH_LSB];
  wire dmacra_word_t rd_word  = (sel_wc == `DMACRA_SEL_WORD_COUNT) ? cur_wc[reg_chan] : cur_addr[reg_chan];
  wire [7:0]    rd_byte    = byte_ff_q ? rd_word[15:8] : rd_word[7:0];

  // Request arbitration, lowest channel first
  wire [3:0]    live_req   = transfer_request_in & ~request_mask;
  wire          any_req    = |live_req;
  wire dmacra_chan_t pick  = live_req[0] ? 2'd0 : live_req[1] ? 2'd1 : live_req[2] ? 2'd2 : 2'd3;
  wire dmacra_word_t xfer_addr = cur_addr[act_chan_q];
  wire          last_word  = cur_wc[act_chan_q] == 16'h0000;
  wire          active     = state_q != DMACRA_IDLE;
  wire          ext_eop    = !end_of_process_n_in && !eop_drive_q;
  wire          end_now    = state_q == DMACRA_S2 && (ext_eop_q || ext_eop || last_word);
  wire          in_xfer    = state_q == DMACRA_S2 || state_q == DMACRA_S4;
  // Registered pin drive follows the next state so it lines up with the strobes
  wire          in_xfer_d  = state_d == DMACRA_S2 || state_d == DMACRA_S4;
  wire dmacra_word_t next_addr = (state_q == DMACRA_S4) ? xfer_addr + 16'h0001 : xfer_addr;

  // Register write and advance feed
  assign rb.wr_en    = selected && wr_end;
  assign rb.sel_wc   = sel_wc;
  assign rb.hi_byte  = byte_ff_q;
  assign rb.chan     = reg_chan;
  assign rb.wdata    = data_bus_pins_in;
  assign rb.adv_en   = state_q == DMACRA_S4;
  assign rb.adv_chan = act_chan_q;

  dmacra_regfile u_regs (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .bus      (rb),
    .cur_addr (cur_addr),
    .cur_wc   (cur_wc)
  );

  // Transfer sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      DMACRA_IDLE: if (any_req && bus_hold_grant) state_d = DMACRA_S1;
      DMACRA_S1:   state_d = DMACRA_S2;
      DMACRA_S2:   state_d = end_now ? DMACRA_IDLE : DMACRA_S4;
      DMACRA_S4:   state_d = (demand_mode && transfer_request_in[act_chan_q]) ? DMACRA_S2 : DMACRA_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst || master_clr) state_q <= DMACRA_IDLE;
    else                   state_q <= state_d;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) act_chan_q <= 2'd0;
    else if (state_q == DMACRA_IDLE) act_chan_q <= pick;
  end

  // Byte order flip-flop
  always_ff @(posedge clk_sys) begin
    if (rst || master_clr || clr_ff) byte_ff_q <= `DMACRA_BYTE_FF_RESET;
    else if (set_ff)                 byte_ff_q <= 1'b1;
    else if (acc_end)                byte_ff_q <= ~byte_ff_q;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
    end else begin
      rd_prev_q <= rd_act;
      wr_prev_q <= wr_act;
    end
  end

  // Processor read data, and upper address byte during transfers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data_q <= 8'h00;
      rd_oe_q   <= 1'b0;
    end else begin
      rd_data_q <= in_xfer_d ? next_addr[15:8] : rd_byte;
      rd_oe_q   <= (selected && rd_act) || in_xfer_d;
    end
  end

  // External end of process latch
  always_ff @(posedge clk_sys) begin
    if (rst || master_clr || !active)    ext_eop_q <= 1'b0;
    else if (state_q == DMACRA_S2)       ext_eop_q <= 1'b0;
    else if (ext_eop)                    ext_eop_q <= 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst || master_clr) begin
      eop_drive_q <= 1'b0;
      tc_q        <= 4'h0;
    end else begin
      eop_drive_q <= state_q == DMACRA_S2 && last_word;
      if (end_now) tc_q[act_chan_q] <= 1'b1;
    end
  end

  // Outputs
  assign data_bus_pins_out     = rd_data_q;
  assign data_bus_pins_oe      = rd_oe_q;
  assign bus_hold_request      = any_req || active;
  assign address_enable_out    = active && bus_hold_grant;
  assign addr_low_out          = xfer_addr[7:0];
  assign strobe_oe             = active && bus_hold_grant;
  assign io_read_strobe_n_out  = !(in_xfer && !dir_mem_to_io);
  assign memory_write_strobe_n = !(in_xfer && !dir_mem_to_io);
  assign memory_read_strobe_n  = !(in_xfer && dir_mem_to_io);
  assign io_write_strobe_n_out = !(in_xfer && dir_mem_to_io);
  assign end_of_process_n_out  = 1'b0;
  assign end_of_process_oe     = eop_drive_q;
  assign terminal_count_flags  = tc_q;
endmodule : dmacra_top
`default_nettype wire

// >>> bench/dmacra_checker.sv
// Port checks on the DMA channel block
`timescale 1ns/1ps
`default_nettype none
module dmacra_checker (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // Inputs
  input wire logic       io_read_strobe_n_in,
  input wire logic [3:0] transfer_request_in,
  input wire logic [3:0] request_mask,
  input wire logic       dir_mem_to_io,
  input wire logic       bus_hold_grant,
  // Outputs
  input wire logic       data_bus_pins_oe,
  input wire logic       bus_hold_request,
  input wire logic       address_enable_out,
  input wire logic       io_read_strobe_n_out,
  input wire logic       io_write_strobe_n_out,
  input wire logic       memory_read_strobe_n,
  input wire logic       memory_write_strobe_n,
  input wire logic       strobe_oe,
  input wire logic       end_of_process_n_out,
  input wire logic       end_of_process_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_hold_req; |(transfer_request_in & ~request_mask) |-> bus_hold_request; endproperty
  a_hold_req: assert property (p_hold_req) else $error("no hold request");
  property p_no_grant; !bus_hold_grant |-> !address_enable_out && !strobe_oe; endproperty
  a_no_grant: assert property (p_no_grant) else $error("bus used without grant");
  property p_strb_aen; strobe_oe |-> address_enable_out; endproperty
  a_strb_aen: assert property (p_strb_aen) else $error("strobes without address enable");
  property p_io_mem; strobe_oe && !dir_mem_to_io |-> io_write_strobe_n_out && memory_read_strobe_n
    && (io_read_strobe_n_out == memory_write_strobe_n); endproperty
  a_io_mem: assert property (p_io_mem) else $error("bad strobe pair to memory");
  property p_mem_io; strobe_oe && dir_mem_to_io |-> io_read_strobe_n_out && memory_write_strobe_n
    && (memory_read_strobe_n == io_write_strobe_n_out); endproperty
  a_mem_io: assert property (p_mem_io) else $error("bad strobe pair to device");
  property p_rd_off; io_read_strobe_n_in && $past(io_read_strobe_n_in) && !address_enable_out
    && !$past(address_enable_out) |-> !data_bus_pins_oe; endproperty
  a_rd_off: assert property (p_rd_off) else $error("data pins driven while idle");
  property p_eop_pulse; end_of_process_oe |=> !end_of_process_oe; endproperty
  a_eop_pulse: assert property (p_eop_pulse) else $error("end pulse too long");
  property p_eop_low; end_of_process_oe |-> !end_of_process_n_out; endproperty
  a_eop_low: assert property (p_eop_low) else $error("end pin not pulled low");
  property p_addr_hi; !io_read_strobe_n_out || !io_write_strobe_n_out |-> data_bus_pins_oe; endproperty
  a_addr_hi: assert property (p_addr_hi) else $error("upper address not driven");
endmodule : dmacra_checker
bind dmacra_top dmacra_checker u_chk (.clk_sys, .rst, .io_read_strobe_n_in, .transfer_request_in, .request_mask,
  .dir_mem_to_io, .bus_hold_grant, .data_bus_pins_oe, .bus_hold_request, .address_enable_out, .io_read_strobe_n_out,
  .io_write_strobe_n_out, .memory_read_strobe_n, .memory_write_strobe_n, .strobe_oe, .end_of_process_n_out,
  .end_of_process_oe);
`default_nettype wire

// >>> bench/dmacra_hold_model.sv
// Host processor model answering the bus hold handshake
`timescale 1ns/1ps
`default_nettype none
module dmacra_hold_model (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Handshake
  input  wire logic slow,
  input  wire logic bus_hold_request,
  input  wire logic address_enable_out,
  output logic      bus_hold_grant
);
  logic [1:0] wait_q;
  // Grant after a delay, withdrawn once hold request and address enable are both low
  always_ff @(posedge clk_sys) begin
    if (rst || (!bus_hold_request && !address_enable_out)) begin
      bus_hold_grant <= 1'h0;
      wait_q         <= 2'h0;
    end else if (bus_hold_request && !bus_hold_grant) begin
      wait_q         <= wait_q + 2'h1;
      bus_hold_grant <= wait_q == (slow ? 2'h3 : 2'h0);
    end
  end
endmodule : dmacra_hold_model
`default_nettype wire

// >>> bench/dmacra_top_tb.sv
// Self-checking bench for the DMA channel block
`timescale 1ns/1ps
`default_nettype none
module dmacra_top_tb;
  logic       clk_sys = 1'h0, rst = 1'h1, chip_select_n = 1'h1, slow = 1'h0, eop_pull = 1'h0;
  logic       io_read_strobe_n_in = 1'h1, io_write_strobe_n_in = 1'h1, demand_mode = 1'h0, dir_mem_to_io = 1'h0;
  logic [3:0] port_addr_in = 4'h0, transfer_request_in = 4'h0, request_mask = 4'hF;
  logic [7:0] din = 8'h00, lo;
  wire logic [7:0] data_bus_pins_in, data_bus_pins_out, addr_low_out;
  wire logic [3:0] terminal_count_flags;
  wire logic  data_bus_pins_oe, bus_hold_request, bus_hold_grant, address_enable_out, strobe_oe, end_of_process_n_in;
  wire logic  io_read_strobe_n_out, io_write_strobe_n_out, memory_read_strobe_n, memory_write_strobe_n;
  wire logic  end_of_process_n_out, end_of_process_oe;
  int         error_cnt = 0, tests_run = 0;
  logic [15:0] rv [8] = '{16'h1234, 16'h0000, 16'hBEEF, 16'hA5C3, 16'h0F1E, 16'hFFFF, 16'h8001, 16'h7E81};
  assign data_bus_pins_in    = data_bus_pins_oe ? data_bus_pins_out : din;
  assign end_of_process_n_in = !(end_of_process_oe || eop_pull);
  initial forever #5 clk_sys = ~clk_sys;
  dmacra_top dut (.clk_sys, .rst, .chip_select_n, .port_addr_in, .data_bus_pins_in, .data_bus_pins_out,
    .data_bus_pins_oe, .io_read_strobe_n_in, .io_write_strobe_n_in, .transfer_request_in, .request_mask,
    .demand_mode, .dir_mem_to_io, .bus_hold_request, .bus_hold_grant, .address_enable_out, .addr_low_out,
    .io_read_strobe_n_out, .io_write_strobe_n_out, .memory_read_strobe_n, .memory_write_strobe_n, .strobe_oe,
    .end_of_process_n_in, .end_of_process_n_out, .end_of_process_oe, .terminal_count_flags);
  dmacra_hold_model host (.clk_sys, .rst, .slow, .bus_hold_request, .address_enable_out, .bus_hold_grant);
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task automatic acc(input logic [3:0] a, input logic wr, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    chip_select_n <= 1'h0;
    port_addr_in <= a;
    din <= d;
    if (wr) io_write_strobe_n_in <= 1'h0;
    else io_read_strobe_n_in <= 1'h0;
    repeat (2) @(posedge clk_sys);
    q = data_bus_pins_out;
    io_write_strobe_n_in <= 1'h1;
    io_read_strobe_n_in <= 1'h1;
    @(posedge clk_sys);
    chip_select_n <= 1'h1;
  endtask : acc
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    acc(4'hC, 1'h1, 8'h00, lo);
    acc(a, 1'h1, v[7:0], lo);
    acc(a, 1'h1, v[15:8], lo);
  endtask : wr16
  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    acc(a, 1'h0, 8'h00, v[7:0]);
    acc(a, 1'h0, 8'h00, v[15:8]);
  endtask : rd16
  task automatic aen_wait(input logic v, input int n);
    for (int k = 0; k < n && address_enable_out !== v; k++) begin
      @(posedge clk_sys);
    end
    if (address_enable_out !== v) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : aen_wait
  task automatic xfer(input logic dir, input logic [15:0] a);
    dir_mem_to_io <= dir;
    transfer_request_in <= 4'h1;
    aen_wait(1'h1, 12);
    @(posedge clk_sys);
    chk({io_read_strobe_n_out, memory_write_strobe_n, memory_read_strobe_n, io_write_strobe_n_out,
      data_bus_pins_oe, data_bus_pins_out, addr_low_out}, {dir ? 4'hC : 4'h3, 1'h1, a});
    transfer_request_in <= 4'h0;
    @(posedge clk_sys);
    chk({end_of_process_oe, address_enable_out, terminal_count_flags[0]}, 3'h5);
    aen_wait(1'h0, 8);
  endtask : xfer
  initial begin
    logic [15:0] v;
    repeat (2) @(posedge clk_sys);
    rst <= 1'h0;
    for (int i = 0; i < 16; i++) begin
      if (i < 8) wr16(i[3:0], rv[i]);
      else begin
        acc(4'hC, 1'h1, 8'h00, lo);
        rd16(i[3:0] - 4'h8, v);
        chk(v, rv[i-8]);
      end
    end
    acc(4'h0, 1'h1, 8'h34, lo);
    acc(4'hD, 1'h1, 8'h00, lo);
    acc(4'h0, 1'h1, 8'h12, lo);
    acc(4'h0, 1'h1, 8'h56, lo);
    acc(4'hC, 1'h1, 8'h00, lo);
    rd16(4'h0, v);
    chk(v, 16'h5612);
    acc(4'hC, 1'h0, 8'h00, lo);
    rd16(4'h0, v);
    chk(v, 16'h1256);
    request_mask <= 4'hE;
    xfer(1'h0, 16'h5612);
    wr16(4'h0, 16'h9ABC);
    slow <= 1'h1;
    xfer(1'h1, 16'h9ABC);
    {dir_mem_to_io, slow, eop_pull, demand_mode} <= 4'h3;
    @(posedge clk_sys);
    {eop_pull, demand_mode, request_mask, transfer_request_in} <= {2'h1, 4'hD, 4'h2};
    aen_wait(1'h1, 8);
    repeat (6) begin
      @(posedge clk_sys);
      chk(address_enable_out, 1'h1);
    end
    eop_pull <= 1'h1;
    @(posedge clk_sys);
    eop_pull <= 1'h0;
    aen_wait(1'h0, 8);
    chk(address_enable_out, 1'h0);
    {demand_mode, transfer_request_in} <= 5'h00;
    repeat (4) @(posedge clk_sys);
    aen_wait(1'h0, 8);
    {request_mask, transfer_request_in} <= 8'hB4;
    aen_wait(1'h1, 12);
    @(posedge clk_sys);
    eop_pull <= 1'h1;
    @(posedge clk_sys);
    eop_pull <= 1'h0;
    repeat (4) @(posedge clk_sys);
    chk(terminal_count_flags, 4'h3);
    transfer_request_in <= 4'h0;
    aen_wait(1'h0, 8);
    acc(4'hC, 1'h0, 8'h00, lo);
    rst <= 1'h1;
    @(posedge clk_sys);
    rst <= 1'h0;
    acc(4'h0, 1'h1, 8'h3C, lo);
    acc(4'hC, 1'h1, 8'h00, lo);
    rd16(4'h0, v);
    chk({terminal_count_flags, v}, 20'h0003C);
    tally_and_finish();
  end
endmodule : dmacra_top_tb
`default_nettype wire
